/* pkg/msdec_map_if.sv */
// Interface: placement and window bounds between the decoder and its map unit
`timescale 1ns/100ps
`default_nettype none
interface msdec_map_if;
  import msdec_pkg::*;
  logic              place_high;
  logic [19:0]       data_lo;
  logic [19:0]       data_hi;
  modport owner (output place_high, input data_lo, input data_hi);
  modport mapper (input place_high, output data_lo, output data_hi);
endinterface : msdec_map_if
`default_nettype wire

/* pkg/msdec_pkg.sv */
// Package: constants and types for the memory space decoder
package msdec_pkg;

  // ---------------------------------------------------------------
  // Address space
  // ---------------------------------------------------------------
  localparam int           ADDR_W       = 20;
  localparam logic [19:0]  SPACE_LAST   = 20'hFFFFF;
  localparam logic [19:0]  RESET_VECTOR = 20'h00000;

  // Data area starts, low placement (RAM size variants small/mid/large)
  localparam logic [19:0]  LO_DATA_SMALL = 20'h0F700;
  localparam logic [19:0]  LO_DATA_MID   = 20'h0F100;
  localparam logic [19:0]  LO_DATA_LARGE = 20'h0EE00;
  localparam logic [19:0]  LO_DATA_END   = 20'h0FFFF;

  // Data area starts, high placement
  localparam logic [19:0]  HI_DATA_SMALL = 20'hFF700;
  localparam logic [19:0]  HI_DATA_MID   = 20'hFF100;
  localparam logic [19:0]  HI_DATA_LARGE = 20'hFEE00;
  localparam logic [19:0]  HI_DATA_END   = 20'hFFFFF;

  // Largest ROM variant: last ROM address
  localparam logic [19:0]  ROM_LAST_LARGE = 20'h1FFFF;

  // Placement instruction operands
  localparam logic [3:0]   PLACE_LOW_OP  = 4'h0;
  localparam logic [3:0]   PLACE_HIGH_OP = 4'hF;

  // Upper address port width
  localparam int           UPPER_W      = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MSDEC_TGT_DATA = 2'b00,
    MSDEC_TGT_ROM  = 2'b01,
    MSDEC_TGT_EXT  = 2'b10,
    MSDEC_TGT_NONE = 2'b11
  } msdec_target_e;

  typedef enum logic [1:0] {
    MSDEC_VAR_SMALL = 2'b00,
    MSDEC_VAR_MID   = 2'b01,
    MSDEC_VAR_LARGE = 2'b10
  } msdec_ram_e;

  typedef enum logic [1:0] {
    MSDEC_ST_UNPLACED = 2'b00,
    MSDEC_ST_LOCKED   = 2'b01
  } msdec_state_e;

endpackage : msdec_pkg

/* rtl/msdec_map.sv */
// Window bound unit: data area limits for the current placement and variant
`timescale 1ns/100ps
`default_nettype none
module msdec_map
  import msdec_pkg::*;
#(
  parameter msdec_ram_e RAM_VARIANT = MSDEC_VAR_LARGE
)(
  msdec_map_if.mapper m
);

  // ---------------------------------------------------------------
  // Bounds
  // ---------------------------------------------------------------
  logic [19:0] lo_start;
  logic [19:0] hi_start;

  // Variant picks the data area start for each placement
  always_comb
  begin
    case (RAM_VARIANT)
      MSDEC_VAR_SMALL:
      begin
        lo_start = LO_DATA_SMALL;
        hi_start = HI_DATA_SMALL;
      end
      MSDEC_VAR_MID:
      begin
        lo_start = LO_DATA_MID;
        hi_start = HI_DATA_MID;
      end
      default:
      begin
        lo_start = LO_DATA_LARGE;
        hi_start = HI_DATA_LARGE;
      end
    endcase
  end

  // Window follows the placement
  assign m.data_lo = m.place_high ? hi_start : lo_start;
  assign m.data_hi = m.place_high ? HI_DATA_END : LO_DATA_END;

endmodule : msdec_map
`default_nettype wire

/* rtl/msdec_top.sv */
// Memory space decoder: steers 20-bit accesses to data area, ROM or external
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Every 20-bit address maps to data area, internal ROM, external memory or none (unmapped).
// - Placement operand selects low or high data area location.
// - Low placement: data area from variant start up to 0FFFFH.
// - Largest ROM and RAM, low placement: ROM 00000H-0EDFFH and 10000H-1FFFFH.
// - Overlapping ROM lost under low placement; data area wins.
// - ROM-less: upper address port floats in reset, drives low after.
// - High placement: data area from variant start up to FFFFFH.
// - Unclaimed addresses go external, only in expansion mode.
module msdec_top
  import msdec_pkg::*;
#(
  parameter msdec_ram_e  RAM_VARIANT = MSDEC_VAR_LARGE,
  parameter logic [19:0] ROM_LAST    = ROM_LAST_LARGE,
  parameter bit          ROM_LESS    = 1'b0
)(
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic              CLK_EN,
  input  wire logic              ACC_VALID,
  input  wire logic [19:0]       ACC_ADDR,
  input  wire logic              EXT_EXPAND,
  input  wire logic              PLACE_STB,
  input  wire logic [3:0]        PLACE_OP,
  output var  logic              SEL_VALID,
  output var  logic [1:0]        SEL_TARGET,
  output var  logic [19:0]       SEL_ADDR,
  output var  logic              PLACE_HIGH,
  output var  logic              PLACE_DONE,
  output var  logic [3:0]        UPPER_ADDR_OUT,
  output var  logic [3:0]        UPPER_ADDR_OE
);

  // ---------------------------------------------------------------
  // Placement state
  // ---------------------------------------------------------------
  msdec_state_e state;
  msdec_map_if  mif ();
  logic         take_place;
  logic         place_bit;

  // Strobe counts only before lock and with a legal operand
  assign take_place = PLACE_STB && (state == MSDEC_ST_UNPLACED) &&
                      ((PLACE_OP == PLACE_LOW_OP) || (PLACE_OP == PLACE_HIGH_OP));

  // One-shot placement latch, low until placed
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      state     <= MSDEC_ST_UNPLACED;
      place_bit <= 1'b0;
    end
    else if (CLK_EN)
    begin
      case (state)
        MSDEC_ST_UNPLACED:
        begin
          if (take_place)
          begin
            place_bit <= (PLACE_OP == PLACE_HIGH_OP);
            state     <= MSDEC_ST_LOCKED;
          end
        end
        MSDEC_ST_LOCKED: state <= MSDEC_ST_LOCKED;
        default:         state <= MSDEC_ST_UNPLACED;
      endcase
    end
  end

  // Placement handed to the window bound unit
  assign mif.place_high = place_bit;

  // Window bounds for the chosen RAM size variant
  msdec_map #(
    .RAM_VARIANT (RAM_VARIANT)
  ) u_map (
    .m (mif.mapper)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic          in_data;
  logic          in_rom;
  msdec_target_e next_target;

  // Window and ROM range hits for the current address
  assign in_data = (ACC_ADDR >= mif.data_lo) && (ACC_ADDR <= mif.data_hi);
  assign in_rom  = !ROM_LESS && (ACC_ADDR <= ROM_LAST);

  // Data area beats ROM, ROM beats external
  always_comb
  begin
    if (in_data)
      next_target = MSDEC_TGT_DATA;
    else if (in_rom)
      next_target = MSDEC_TGT_ROM;
    else if (EXT_EXPAND)
      next_target = MSDEC_TGT_EXT;
    else
      next_target = MSDEC_TGT_NONE;
  end

  // Registered select outputs, one cycle after the request
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      SEL_VALID  <= 1'b0;
      SEL_TARGET <= MSDEC_TGT_NONE;
      SEL_ADDR   <= RESET_VECTOR;
    end
    else if (CLK_EN)
    begin
      SEL_VALID  <= ACC_VALID;
      SEL_TARGET <= next_target;
      SEL_ADDR   <= ACC_ADDR;
    end
  end

  // Placement status outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      PLACE_HIGH <= 1'b0;
      PLACE_DONE <= 1'b0;
    end
    else if (CLK_EN)
    begin
      PLACE_HIGH <= take_place ? (PLACE_OP == PLACE_HIGH_OP) : place_bit;
      PLACE_DONE <= take_place || (state == MSDEC_ST_LOCKED);
    end
  end

  // ---------------------------------------------------------------
  // Upper address port
  // ---------------------------------------------------------------
  // Floats in reset; ROM-less part drives low afterwards
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      UPPER_ADDR_OUT <= 4'h0;
      UPPER_ADDR_OE  <= 4'h0;
    end
    else if (CLK_EN)
    begin
      UPPER_ADDR_OUT <= 4'h0;
      UPPER_ADDR_OE  <= ROM_LESS ? 4'hF : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  // Decode checks
  data_prio_a: assert property (CLK_EN && ACC_VALID && in_data
    |=> SEL_TARGET == MSDEC_TGT_DATA)
    else $error("data area lost priority");
  low_window_a: assert property (CLK_EN && ACC_VALID && !place_bit &&
    ACC_ADDR == LO_DATA_END |=> SEL_TARGET == MSDEC_TGT_DATA)
    else $error("low window top not data");
  high_window_a: assert property (CLK_EN && ACC_VALID && place_bit &&
    ACC_ADDR == HI_DATA_END |=> SEL_TARGET == MSDEC_TGT_DATA)
    else $error("high window top not data");
  rom_above_a: assert property (CLK_EN && !ROM_LESS && !in_data && ACC_ADDR <= ROM_LAST
    |=> SEL_TARGET == MSDEC_TGT_ROM)
    else $error("rom address not steered to rom");
  ext_gate_a: assert property (CLK_EN && !EXT_EXPAND |=> SEL_TARGET != MSDEC_TGT_EXT)
    else $error("external select without expansion");
  ext_fwd_a: assert property (CLK_EN && EXT_EXPAND && !in_data && !in_rom
    |=> SEL_TARGET == MSDEC_TGT_EXT)
    else $error("unclaimed address not forwarded");
  unmapped_a: assert property (CLK_EN && !EXT_EXPAND && !in_data && !in_rom
    |=> SEL_TARGET == MSDEC_TGT_NONE)
    else $error("unclaimed address not marked unmapped");
  romless_rom_a: assert property (CLK_EN && ROM_LESS |=> SEL_TARGET != MSDEC_TGT_ROM)
    else $error("rom selected on rom-less part");
  sel_follow_a: assert property (CLK_EN |=> SEL_VALID == $past(ACC_VALID))
    else $error("select valid does not follow request");

  // Placement checks
  place_lock_a: assert property (PLACE_DONE && CLK_EN |=> $stable(PLACE_HIGH))
    else $error("placement changed after lock");
  place_take_a: assert property (CLK_EN && take_place |=> PLACE_DONE &&
    PLACE_HIGH == ($past(PLACE_OP) == PLACE_HIGH_OP))
    else $error("placement not taken");

  // Port and freeze checks
  upper_drive_a: assert property (CLK_EN |=> UPPER_ADDR_OUT == 4'h0 &&
    UPPER_ADDR_OE == (ROM_LESS ? 4'hF : 4'h0))
    else $error("upper port drive wrong after reset");
  upper_float_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
    !RESET_N |=> UPPER_ADDR_OE == 4'h0)
    else $error("upper port driven during reset");
  freeze_hold_a: assert property (!CLK_EN |=> $stable(SEL_VALID) && $stable(SEL_ADDR) &&
    $stable(PLACE_DONE))
    else $error("state moved while clock enable low");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  cov_place_hi_c: cover property (CLK_EN && take_place && PLACE_OP == PLACE_HIGH_OP);
  cov_second_c:   cover property (CLK_EN && PLACE_STB && state == MSDEC_ST_LOCKED);
  cov_ext_c:      cover property (SEL_VALID && SEL_TARGET == MSDEC_TGT_EXT);
  cov_lo_data_c:  cover property (SEL_VALID && SEL_TARGET == MSDEC_TGT_DATA && !PLACE_HIGH);
  cov_freeze_c:   cover property (!CLK_EN && ACC_VALID);

endmodule : msdec_top
`default_nettype wire

/* tb/msdec_core_model.sv */
// Processor core model: reset vector fetch, placement and access requests
`timescale 1ns/100ps
`default_nettype none
module msdec_core_model
  import msdec_pkg::*;
(
  input  wire logic        clk,
  output var  logic        acc_valid,
  output var  logic [19:0] acc_addr,
  output var  logic        place_stb,
  output var  logic [3:0]  place_op
);
  // Idle request lines at time zero
  initial
  begin
    acc_valid = 1'b0;
    acc_addr  = 20'h00000;
    place_stb = 1'b0;
    place_op  = 4'h0;
  end

  // One access; the released address shows its inverse
  task automatic access(input logic [19:0] a);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
  endtask : access

  // One placement strobe, one cycle wide
  task automatic place(input logic [3:0] op);
    @(posedge clk);
    place_stb <= 1'b1;
    place_op  <= op;
    @(posedge clk);
    place_stb <= 1'b0;
    place_op  <= ~op;
  endtask : place

  // Start: fetch the vector word, then place as the first instruction
  task automatic boot(input logic [3:0] op);
    access(RESET_VECTOR);
    place(op);
  endtask : boot
endmodule : msdec_core_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the memory space decoder
`timescale 1ns/100ps
`default_nettype none
module testbench
  import msdec_pkg::*;
;
  logic        clk_sys;
  logic        reset_n;
  logic        ext_expand;
  logic        acc_valid;
  logic [19:0] acc_addr;
  logic        place_stb;
  logic [3:0]  place_op;
  logic        sel_valid;
  logic [1:0]  sel_target;
  logic [19:0] sel_addr;
  logic        place_high;
  logic        place_done;
  logic [3:0]  oe_romless;
  logic [3:0]  oe_main;
  logic [3:0]  out_romless;
  logic [1:0]  sel_target_rl;
  logic        clk_en;
  int          err_total;
  int          n_tests;
  localparam logic [19:0] LO_A [7] = '{20'h0EE00, 20'h0FFFF, 20'h0EDFF, 20'h00000,
                                       20'h10000, 20'h1FFFF, 20'h20000};
  localparam logic [1:0]  LO_T [7] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b01, 2'b01, 2'b10};

  msdec_core_model core_inst (.clk(clk_sys), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .place_stb(place_stb), .place_op(place_op));
  msdec_top msdec_top_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en),
    .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .EXT_EXPAND(ext_expand),
    .PLACE_STB(place_stb), .PLACE_OP(place_op), .SEL_VALID(sel_valid),
    .SEL_TARGET(sel_target), .SEL_ADDR(sel_addr), .PLACE_HIGH(place_high),
    .PLACE_DONE(place_done), .UPPER_ADDR_OUT(), .UPPER_ADDR_OE(oe_main));
  msdec_top #(.ROM_LESS(1'b1)) msdec_top_romless_inst (.CLK_SYS(clk_sys),
    .RESET_N(reset_n), .CLK_EN(clk_en), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr),
    .EXT_EXPAND(ext_expand), .PLACE_STB(place_stb), .PLACE_OP(place_op), .SEL_VALID(),
    .SEL_TARGET(sel_target_rl), .SEL_ADDR(), .PLACE_HIGH(), .PLACE_DONE(),
    .UPPER_ADDR_OUT(out_romless), .UPPER_ADDR_OE(oe_romless));

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One access and its registered decode
  task automatic dec(input logic [19:0] a, input logic [1:0] t);
    core_inst.access(a);
    #1;
    chk("SEL_TARGET", {18'h0, t}, {18'h0, sel_target});
    chk("SEL_ADDR", a, sel_addr);
    chk("SEL_VALID", 20'h1, {19'h0, sel_valid});
  endtask : dec

  // Reset for 9 cycles; ports float in reset, only the ROM-less port drives after
  task automatic t_reset;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("UPPER_ADDR_OE", 20'h0, {16'h0, oe_romless});
    chk("UPPER_ADDR_OE_MAIN", 20'h0, {16'h0, oe_main});
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("UPPER_ADDR_OE", 20'hF, {16'h0, oe_romless});
    chk("UPPER_ADDR_OUT", 20'h0, {16'h0, out_romless});
    chk("UPPER_ADDR_OE_MAIN", 20'h0, {16'h0, oe_main});
    chk("PLACE_DONE", 20'h0, {19'h0, place_done});
    chk("PLACE_HIGH", 20'h0, {19'h0, place_high});
  endtask : t_reset

  // Default low map, ROM hole and external forwarding
  task automatic t_low_map;
    for (int i = 0; i < 7; i++)
      dec(LO_A[i], LO_T[i]);
    dec(20'h00000, 2'b01);
    chk("SEL_TARGET_RL", 20'h2, {18'h0, sel_target_rl});
    @(posedge clk_sys);
    ext_expand <= 1'b0;
    dec(20'h20000, 2'b11);
    @(posedge clk_sys);
    ext_expand <= 1'b1;
  endtask : t_low_map

  // Clock enable low freezes decode and placement
  task automatic t_freeze;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    core_inst.access(20'h0EE00);
    core_inst.place(PLACE_HIGH_OP);
    #1;
    chk("SEL_VALID", 20'h0, {19'h0, sel_valid});
    chk("PLACE_DONE", 20'h0, {19'h0, place_done});
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask : t_freeze

  // Bad operand ignored, high placement, later low ignored
  task automatic t_high;
    core_inst.place(4'h5);
    #1;
    chk("PLACE_DONE", 20'h0, {19'h0, place_done});
    core_inst.boot(PLACE_HIGH_OP);
    #1;
    chk("PLACE_HIGH", 20'h1, {19'h0, place_high});
    dec(20'hFEE00, 2'b00);
    dec(20'hFFFFF, 2'b00);
    dec(20'hFEDFF, 2'b10);
    dec(20'h0EE00, 2'b01);
    core_inst.place(PLACE_LOW_OP);
    #1;
    chk("PLACE_HIGH", 20'h1, {19'h0, place_high});
    dec(20'hFEE00, 2'b00);
  endtask : t_high

  // Second reset, low placement locks out a later high one
  task automatic t_low_lock;
    t_reset();
    core_inst.boot(PLACE_LOW_OP);
    core_inst.place(PLACE_HIGH_OP);
    #1;
    chk("PLACE_DONE", 20'h1, {19'h0, place_done});
    chk("PLACE_HIGH", 20'h0, {19'h0, place_high});
    dec(20'h0EE00, 2'b00);
    dec(20'hFEE00, 2'b10);
  endtask : t_low_lock

  // Counts and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    err_total  = 0;
    n_tests    = 0;
    reset_n    = 1'b0;
    ext_expand = 1'b1;
    clk_en     = 1'b1;
    t_reset();
    t_low_map();
    t_freeze();
    t_high();
    t_low_lock();
    test_done();
  end

  // Watchdog well beyond the under one hundred cycles of the run
  initial
  begin
    #20000;
    err_total++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
